// ===== rtl/isa_cycle_control.sv
// Purpose: steers cpu cycles to system memory or isa, sizes and times isa cycles
// Assumes: one clock hclk (processor clock); isa pins synchronous to it
// Notes: cs16 inputs are active low and iochrdy is active high; strobes are active low
`timescale 1ns/1ns
`include "isa_cycle_consts.svh"
// Function
// - system ram/rom hits run a memory cycle; anything else runs an isa cycle
// - memory strobes stay inactive on every system ram access
// - read strobe may act as rom output enable; card cycles may use both strobes
// - card strobes on gpio float while the card slot is unpowered
// - 16-bit io needs iocs16 enabled; 16-bit memory needs memcs16 enabled
// - 16-bit request without cs16 answer becomes two byte transfers
// - cs16 answer from the peripheral gives one 16-bit transfer
// - gpio may output byte high enable and the bus clock
// - isa cycles are timed from bus clock at half, third or quarter rate
// - divisor field bits 1:0 pick divide by 4, 3, 2; default 2
// - oscillator divisor bits 6:5 pick crystal divide 1 to 4; default 2
// - mode bits 7:6 pick stop, sync or stretch; default stop
// - stop mode runs the bus clock only during an isa cycle
// - sync mode runs freely; cycle waits for phase start, at most four clocks
// - stretch mode holds the current clock phase until the cycle starts
// - memcs16 counts only if enabled and low before the second cycle state
// - split transfers go even byte first, odd byte second
// - iochrdy adds waits on isa cycles only, never on system memory
module isa_cycle_control (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire isa_cycle_pkg::cpu_req_t cpu_req,
    output logic cpu_done,
    output logic [15:0] cpu_rdata,
    output logic sysmem_start,
    input wire logic iocs16_n,
    input wire logic memcs16_n,
    input wire logic iochrdy,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe_n,
    output logic [19:0] isa_addr,
    output isa_cycle_pkg::isa_cmd_t isa_cmd,
    output logic rom_oe_n,
    output logic card_strobe_oe_n,
    output logic gpio_bhe_n,
    output logic gpio_sysclk,
    output logic [1:0] oscillator_divisor
);
    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    logic [7:0] bcg_mode;
    logic [7:0] expansion_bus_mode;
    logic [7:0] bus_ctrl;
    logic wr_pend;
    logic [9:0] wr_addr;
    logic [1:0] bus_clock_divisor;
    isa_cycle_pkg::clk_mode_t bus_clock_mode;
    isa_cycle_pkg::isa_state_t state;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // capture write address phase, data follows next cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 10'h000;
        end else if (hready) begin
            wr_pend <= hsel && htrans[1] && hwrite && (hsize == 3'h2);
            wr_addr <= haddr[9:0];
        end
    end

    // register write; unmapped addresses are ignored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bcg_mode <= `BCG_MODE_RESET;
            expansion_bus_mode <= `EXP_BUS_MODE_RESET;
            bus_ctrl <= `BUS_CTRL_RESET;
        end else if (wr_pend) begin
            case (wr_addr)
                `BCG_MODE_ADDR: bcg_mode <= hwdata[7:0];
                `EXP_BUS_MODE_ADDR: expansion_bus_mode <= hwdata[7:0];
                `BUS_CTRL_ADDR: bus_ctrl <= hwdata[7:0];
                default: ;
            endcase
        end
    end

    // read data registered; unmapped reads as zero; low bit 31..8 zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            case (haddr[9:0])
                `BCG_MODE_ADDR: hrdata <= {24'h000000, bcg_mode};
                `EXP_BUS_MODE_ADDR: hrdata <= {24'h000000, expansion_bus_mode};
                `BUS_CTRL_ADDR: hrdata <= {24'h000000, state, bus_ctrl[4:0]};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    assign oscillator_divisor = bcg_mode[`OSC_LSB +: 2];

    // ------------------------------------------------------------
    // bus clock generator
    // ------------------------------------------------------------
    logic [1:0] phase_cnt;
    logic [1:0] div_last;
    logic [1:0] low_from;
    logic sysclk;
    logic sys_edge;
    logic clk_run;
    logic hold_phase;

    // settings latched only while idle so a running cycle keeps its timing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_clock_divisor <= 2'b10;
            bus_clock_mode <= isa_cycle_pkg::clk_stop;
        end else if (state == isa_cycle_pkg::st_idle && !cpu_req.valid) begin
            bus_clock_divisor <= bcg_mode[`DIV_LSB +: 2];
            bus_clock_mode <= isa_cycle_pkg::clk_mode_t'(expansion_bus_mode[`MODE_LSB +: 2]);
        end
    end

    // reserved divisor code behaves as divide by two
    always_comb begin
        case (bus_clock_divisor)
            2'b00: div_last = 2'd3;
            2'b01: div_last = 2'd2;
            default: div_last = 2'd1;
        endcase
        low_from = (div_last == 2'd2) ? 2'd1 : ((div_last == 2'd3) ? 2'd2 : 2'd1);
    end

    assign clk_run = (bus_clock_mode != isa_cycle_pkg::clk_stop) ||
                     (state != isa_cycle_pkg::st_idle && state != isa_cycle_pkg::st_align);
    assign hold_phase = (bus_clock_mode == isa_cycle_pkg::clk_stretch) &&
                        (state == isa_cycle_pkg::st_align);
    assign sys_edge = clk_run && !hold_phase && (phase_cnt == div_last);

    // phase counter; stop mode parks it at the cycle boundary
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_cnt <= 2'd0;
        end else if (!clk_run || hold_phase) begin
            phase_cnt <= hold_phase ? phase_cnt : 2'd0;
        end else if (phase_cnt == div_last) begin
            phase_cnt <= 2'd0;
        end else begin
            phase_cnt <= phase_cnt + 2'd1;
        end
    end

    // the bus clock flop lives in the isa_cmd process so the struct has one driver
    assign sysclk = isa_cmd.sysclk;

    assign gpio_sysclk = bus_ctrl[`CTRL_CLK_OUT] ? sysclk : 1'b0;

    // ------------------------------------------------------------
    // cycle sequencer
    // ------------------------------------------------------------
    logic [3:0] st_cnt;
    logic wide_now;
    logic odd_half;
    logic split;
    logic [15:0] rdata_acc;
    logic is_wide_req;
    logic isa_hit;
    logic cmd_on;

    assign isa_hit = cpu_req.valid && !cpu_req.is_ram && !cpu_req.is_rom;
    assign sysmem_start = (state == isa_cycle_pkg::st_idle) && cpu_req.valid &&
                          (cpu_req.is_ram || cpu_req.is_rom);
    assign is_wide_req = cpu_req.wide && !cpu_req.addr[0];

    // sequencing of align, lead, command and split halves
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= isa_cycle_pkg::st_idle;
            st_cnt <= 4'h0;
            wide_now <= 1'b0;
            odd_half <= 1'b0;
            split <= 1'b0;
        end else begin
            case (state)
                isa_cycle_pkg::st_idle: begin
                    odd_half <= 1'b0;
                    split <= 1'b0;
                    wide_now <= 1'b0;
                    if (isa_hit) begin
                        state <= isa_cycle_pkg::st_align;
                    end
                end
                isa_cycle_pkg::st_align: begin
                    // sync mode waits for the boundary, at most a full period
                    if (bus_clock_mode != isa_cycle_pkg::clk_sync || sys_edge) begin
                        state <= isa_cycle_pkg::st_lead;
                        st_cnt <= 4'h0;
                    end
                end
                isa_cycle_pkg::st_lead: begin
                    if (sys_edge) begin
                        // sample before second state begins
                        if (cpu_req.is_io) begin
                            wide_now <= is_wide_req && !odd_half && bus_ctrl[`CTRL_IOCS16_EN] &&
                                        !iocs16_n;
                        end else begin
                            wide_now <= is_wide_req && !odd_half && bus_ctrl[`CTRL_MEMCS16_EN] &&
                                        !memcs16_n;
                        end
                        state <= isa_cycle_pkg::st_cmd;
                        st_cnt <= 4'h1;
                    end
                end
                isa_cycle_pkg::st_cmd: begin
                    if (sys_edge) begin
                        if (st_cnt >= `CYCLE_STATES - 4'h1 && iochrdy) begin
                            state <= isa_cycle_pkg::st_done;
                        end else if (st_cnt < `CYCLE_STATES) begin
                            st_cnt <= st_cnt + 4'h1;
                        end
                    end
                end
                isa_cycle_pkg::st_done: begin
                    if (is_wide_req && !wide_now && !odd_half) begin
                        odd_half <= 1'b1;
                        split <= 1'b1;
                        state <= isa_cycle_pkg::st_align;
                    end else begin
                        state <= isa_cycle_pkg::st_idle;
                    end
                end
                default: state <= isa_cycle_pkg::st_idle;
            endcase
        end
    end

    assign cmd_on = (state == isa_cycle_pkg::st_cmd);

    // address, data and read capture from flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            isa_addr <= 20'h00000;
            data_out <= 16'h0000;
            data_oe_n <= 1'b1;
            rdata_acc <= 16'h0000;
        end else begin
            isa_addr <= {cpu_req.addr[19:1], cpu_req.addr[0] | odd_half};
            data_out <= (odd_half && !cpu_req.addr[0]) ? {cpu_req.wdata[15:8], cpu_req.wdata[15:8]}
                                                       : cpu_req.wdata;
            data_oe_n <= !(state != isa_cycle_pkg::st_idle && cpu_req.write);
            if (state == isa_cycle_pkg::st_cmd && sys_edge && iochrdy) begin
                if (wide_now || !is_wide_req) begin
                    rdata_acc <= data_in;
                end else if (!odd_half) begin
                    rdata_acc[7:0] <= data_in[7:0];
                end else begin
                    rdata_acc[15:8] <= data_in[7:0];
                end
            end
        end
    end

    assign cpu_rdata = rdata_acc;
    assign cpu_done = (state == isa_cycle_pkg::st_done) && !(is_wide_req && !wide_now && !odd_half);

    // strobes and bus clock; memory strobes never on a ram access
    // bus clock is high for the first part of the period, low for the rest
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            isa_cmd.mem_read_strobe_n <= 1'b1;
            isa_cmd.mem_write_strobe_n <= 1'b1;
            isa_cmd.io_read_strobe_n <= 1'b1;
            isa_cmd.io_write_strobe_n <= 1'b1;
            isa_cmd.bhe_n <= 1'b1;
            isa_cmd.sysclk <= 1'b0;
            rom_oe_n <= 1'b1;
        end else begin
            isa_cmd.mem_read_strobe_n <= !(cmd_on && !cpu_req.is_io && !cpu_req.write);
            isa_cmd.mem_write_strobe_n <= !(cmd_on && !cpu_req.is_io && cpu_req.write);
            isa_cmd.io_read_strobe_n <= !(cmd_on && cpu_req.is_io && !cpu_req.write);
            isa_cmd.io_write_strobe_n <= !(cmd_on && cpu_req.is_io && cpu_req.write);
            isa_cmd.bhe_n <= !((is_wide_req && !split) || odd_half || cpu_req.addr[0]);
            rom_oe_n <= !(bus_ctrl[`CTRL_ROM_OE] && sysmem_start && cpu_req.is_rom &&
                          !cpu_req.write);
            isa_cmd.sysclk <= clk_run && (phase_cnt < low_from);
        end
    end

    assign gpio_bhe_n = bus_ctrl[`CTRL_BHE_OUT] ? isa_cmd.bhe_n : 1'b1;
    assign card_strobe_oe_n = !bus_ctrl[`CTRL_CARD_PWR];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    ram_no_strobe_a: assert property (@(posedge hclk) disable iff (!hresetn)
        sysmem_start |-> ##1 isa_cmd.mem_read_strobe_n && isa_cmd.mem_write_strobe_n)
        else $error("memory strobe on system memory");
    card_float_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !bus_ctrl[`CTRL_CARD_PWR] |-> card_strobe_oe_n)
        else $error("card strobes driven while unpowered");
    route_sys_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == isa_cycle_pkg::st_idle && cpu_req.valid && cpu_req.is_ram) |=>
        state == isa_cycle_pkg::st_idle)
        else $error("isa cycle for system ram");
    route_isa_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == isa_cycle_pkg::st_idle && isa_hit) |=> state == isa_cycle_pkg::st_align)
        else $error("no isa cycle for expansion access");
    io_narrow_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == isa_cycle_pkg::st_cmd && cpu_req.is_io && !bus_ctrl[`CTRL_IOCS16_EN]) |->
        !wide_now)
        else $error("wide io without iocs16 enabled");
    split_odd_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == isa_cycle_pkg::st_done && is_wide_req && !wide_now && !odd_half) |=>
        odd_half && state == isa_cycle_pkg::st_align)
        else $error("narrow answer not split");
    stop_clock_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (bus_clock_mode == isa_cycle_pkg::clk_stop && state == isa_cycle_pkg::st_idle) |->
        !sys_edge)
        else $error("bus clock runs while stopped");
    sync_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == isa_cycle_pkg::st_align && bus_clock_mode == isa_cycle_pkg::clk_sync) |->
        ##[0:4] state != isa_cycle_pkg::st_align)
        else $error("sync alignment over four clocks");
    ready_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == isa_cycle_pkg::st_cmd && !iochrdy) |=> state != isa_cycle_pkg::st_done)
        else $error("cycle ended while not ready");
    wide_cover_c: cover property (@(posedge hclk) state == isa_cycle_pkg::st_done && wide_now);
    split_cover_c: cover property (@(posedge hclk) cpu_done && split);
    stretch_cover_c: cover property (@(posedge hclk) hold_phase);
endmodule : isa_cycle_control

// ===== rtl/isa_cycle_consts.svh
// Purpose: offsets, field positions, reset values and counts of the isa cycle controller
// Assumes: 32-bit ahb-lite word per register
// Notes: printed indices are not all multiples of four, so byte address is four times index
`ifndef ISA_CYCLE_CONSTS_SVH
`define ISA_CYCLE_CONSTS_SVH
`define BCG_MODE_INDEX 8'h01
`define EXP_BUS_MODE_INDEX 8'h34
`define BUS_CTRL_INDEX 8'h3c
`define BCG_MODE_ADDR 10'h004
`define EXP_BUS_MODE_ADDR 10'h0d0
`define BUS_CTRL_ADDR 10'h0f0
`define BCG_MODE_RESET 8'h22
`define EXP_BUS_MODE_RESET 8'h00
`define BUS_CTRL_RESET 8'h00
`define DIV_LSB 0
`define OSC_LSB 5
`define MODE_LSB 6
`define CTRL_IOCS16_EN 0
`define CTRL_MEMCS16_EN 1
`define CTRL_ROM_OE 2
`define CTRL_CARD_PWR 3
`define CTRL_BHE_OUT 4
`define CTRL_CLK_OUT 5
`define CYCLE_STATES 4'h3
`endif

// ===== rtl/isa_cycle_pkg.sv
// Purpose: types shared by the isa cycle controller
// Assumes: nothing
// Notes: carriers for the cpu request and isa pin groups
package isa_cycle_pkg;
    typedef enum logic [1:0] {
        clk_stop = 2'b00,
        clk_sync = 2'b01,
        clk_stretch = 2'b10
    } clk_mode_t;
    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_align = 3'b001,
        st_lead = 3'b011,
        st_cmd = 3'b010,
        st_done = 3'b110
    } isa_state_t;
    typedef struct packed {
        logic valid;
        logic write;
        logic is_io;
        logic is_ram;
        logic is_rom;
        logic is_card;
        logic wide;
        logic [19:0] addr;
        logic [15:0] wdata;
    } cpu_req_t;
    typedef struct packed {
        logic mem_read_strobe_n;
        logic mem_write_strobe_n;
        logic io_read_strobe_n;
        logic io_write_strobe_n;
        logic bhe_n;
        logic sysclk;
    } isa_cmd_t;
endpackage : isa_cycle_pkg

// ===== testbench/isa_peripheral_model.sv
// Purpose: isa peripheral on the far side of the isa cycle controller
// Assumes: strobes active low, synchronous to hclk
// Notes: released data lines show the inverse of the last value read
`timescale 1ns/1ns
module isa_peripheral_model (
    input wire logic hclk,
    input wire isa_cycle_pkg::isa_cmd_t isa_cmd,
    input wire logic [19:0] isa_addr,
    input wire logic wide_io,
    input wire logic wide_mem,
    input wire logic [3:0] wait_cycles,
    output logic iocs16_n,
    output logic memcs16_n,
    output logic iochrdy,
    output logic [15:0] data_in
);
    logic reading;
    logic active;
    logic [3:0] held = 4'h0;
    logic [15:0] last = 16'h0000;
    logic [15:0] pat;
    // any command strobe low marks a cycle in progress
    assign reading = !isa_cmd.io_read_strobe_n || !isa_cmd.mem_read_strobe_n;
    assign active = reading || !isa_cmd.io_write_strobe_n || !isa_cmd.mem_write_strobe_n;
    assign pat = {isa_addr[7:0] ^ 8'ha5, isa_addr[7:0]};
    // a wide peer pulls its select low from the wide_io or wide_mem flag alone
    assign iocs16_n = !wide_io;
    assign memcs16_n = !wide_mem;
    // ready stays low for wait_cycles of each strobe, a slow peer
    assign iochrdy = !active || (held >= wait_cycles);
    // stale data must never look like a good read
    assign data_in = reading ? pat : ~last;
    always @(posedge hclk) begin
        held <= !active ? 4'h0 : ((held == 4'hf) ? held : held + 4'h1);
        if (reading) begin
            last <= pat;
        end
    end
endmodule : isa_peripheral_model

// ===== testbench/isa_cycle_control_tb.sv
// Purpose: self-checking bench for the isa cycle controller
// Assumes: ahb-lite register access, one clock
// Notes: strobe falls and bus clock edges are counted by monitors
`timescale 1ns/1ns
`include "isa_cycle_consts.svh"
module isa_cycle_control_tb;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'b00, osc;
    logic [2:0] hsize = 3'b010;
    logic hreadyout, hresp, cpu_done, sysmem_start, iocs16_n, memcs16_n, iochrdy;
    logic data_oe_n, rom_oe_n, card_oe_n, gpio_bhe_n, gpio_sysclk;
    logic [15:0] cpu_rdata, data_in, data_out;
    logic [19:0] isa_addr;
    logic wide_io = 1'b0, wide_mem = 1'b0, op_wr = 1'b0, oe_seen, bhe_seen;
    logic [15:0] wr_seen;
    logic [3:0] wait_cycles = 4'h0;
    isa_cycle_pkg::cpu_req_t cpu_req = '0;
    isa_cycle_pkg::isa_cmd_t isa_cmd;
    int fails = 0, checked = 0, cycles = 0, rises = 0, grises = 0, n, n_fast;
    int io_falls = 0, mem_falls = 0, i0, m0, r0, g0;
    logic [19:0] addr_q[$];
    assign hready = hreadyout;
    always #2 hclk = ~hclk;
    isa_cycle_control dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cpu_req(cpu_req),
        .cpu_done(cpu_done), .cpu_rdata(cpu_rdata), .sysmem_start(sysmem_start),
        .iocs16_n(iocs16_n), .memcs16_n(memcs16_n), .iochrdy(iochrdy), .data_in(data_in),
        .data_out(data_out), .data_oe_n(data_oe_n), .isa_addr(isa_addr), .isa_cmd(isa_cmd),
        .rom_oe_n(rom_oe_n), .card_strobe_oe_n(card_oe_n), .gpio_bhe_n(gpio_bhe_n),
        .gpio_sysclk(gpio_sysclk), .oscillator_divisor(osc));
    isa_peripheral_model peer (.hclk(hclk), .isa_cmd(isa_cmd), .isa_addr(isa_addr),
        .wide_io(wide_io), .wide_mem(wide_mem), .wait_cycles(wait_cycles),
        .iocs16_n(iocs16_n), .memcs16_n(memcs16_n), .iochrdy(iochrdy), .data_in(data_in));
    // ----------------------------------------
    // monitors
    // ----------------------------------------
    // read strobe falls record the byte address for ordering checks
    always @(negedge isa_cmd.io_read_strobe_n) begin
        io_falls++;
        addr_q.push_back(isa_addr);
    end
    always @(negedge isa_cmd.mem_read_strobe_n) begin
        mem_falls++;
        addr_q.push_back(isa_addr);
    end
    // memory write strobe falls capture what the data lanes carry
    always @(negedge isa_cmd.mem_write_strobe_n) begin
        mem_falls++;
        wr_seen = data_out;
        oe_seen = data_oe_n;
        bhe_seen = gpio_bhe_n;
    end
    always @(posedge isa_cmd.sysclk) rises++;
    always @(posedge gpio_sysclk) grises++;
    // a hang counts as a mismatch
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            end_sim();
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // one single word transfer; waits on hready in both phases
    task ahb(input logic wr, input logic [9:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {22'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    // request held until done, then dropped; op_wr picks read or write
    task cpu_op(input logic io, input logic wide, input logic [19:0] a);
        @(posedge hclk);
        cpu_req <= '{valid: 1'b1, write: op_wr, is_io: io, is_ram: 1'b0, is_rom: 1'b0,
            is_card: 1'b0, wide: wide, addr: a, wdata: 16'hc3a5};
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (cpu_done !== 1'b1 && n < 400);
        cpu_req.valid <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask : cpu_op
    task clk_count;
        repeat (8) @(posedge hclk);
        r0 = rises;
        g0 = grises;
        repeat (24) @(posedge hclk);
    endtask : clk_count
    task end_sim;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, `BCG_MODE_ADDR, 32'h0);
        check("bcg_mode reset", rd, 32'h22);
        check("osc divisor", {30'h0, osc}, 32'h1);
        ahb(1'b0, `EXP_BUS_MODE_ADDR, 32'h0);
        check("exp_bus_mode reset", rd, 32'h0);
        ahb(1'b1, 10'h100, 32'hff);
        ahb(1'b0, 10'h100, 32'h0);
        check("unmapped read", rd, 32'h0);
        check("resp okay", {31'h0, hresp}, 32'h0);
        check("card unpowered", {31'h0, card_oe_n}, 32'h1);
        clk_count();
        check("stop idle clock", rises - r0, 0);
        // bus sizing table: io/mem, select enable, wide peer
        for (int k = 0; k < 5; k++) begin
            logic io, en, wp;
            io = (k < 3);
            en = (k != 1) && (k != 4);
            wp = (k != 2);
            wide_io <= io & wp;
            wide_mem <= !io & wp;
            ahb(1'b1, `BUS_CTRL_ADDR, {30'h0, !io & en, io & en});
            i0 = io_falls;
            m0 = mem_falls;
            r0 = rises;
            addr_q.delete();
            cpu_op(io, 1'b1, 20'h00310);
            check("cycle ran", {31'h0, rises > r0}, 32'h1);
            check("rdata", cpu_rdata, (en & wp) ? 32'hb510 : 32'h1110);
            check("strobes", io ? io_falls - i0 : mem_falls - m0, (en & wp) ? 1 : 2);
            if (!(en & wp)) begin
                check("even first", addr_q[0], 32'h00310);
                check("odd second", addr_q[1], 32'h00311);
            end
            clk_count();
            check("stop after", rises - r0, 0);
        end
        // a slow peer must lengthen the isa cycle
        n_fast = n;
        wait_cycles <= 4'h8;
        cpu_op(1'b0, 1'b1, 20'h00310);
        check("iochrdy waits", {31'h0, n > n_fast}, 32'h1);
        wait_cycles <= 4'h0;
        // a wide memory write drives the data lanes and byte high enable
        ahb(1'b1, `BUS_CTRL_ADDR, 32'h12);
        m0 = mem_falls;
        op_wr = 1'b1;
        cpu_op(1'b0, 1'b1, 20'h00310);
        op_wr = 1'b0;
        check("write strobes", mem_falls - m0, 1);
        check("write data", {16'h0, wr_seen}, 32'hc3a5);
        check("data driven", {31'h0, oe_seen}, 32'h0);
        check("gpio bhe", {31'h0, bhe_seen}, 32'h0);
        // system ram and rom hits leave the isa strobes alone
        ahb(1'b1, `BUS_CTRL_ADDR, 32'h4);
        for (int k = 0; k < 2; k++) begin
            m0 = mem_falls;
            i0 = io_falls;
            @(posedge hclk);
            cpu_req <= '{valid: 1'b1, write: 1'b0, is_io: 1'b0, is_ram: k == 0,
                is_rom: k == 1, is_card: 1'b0, wide: 1'b0, addr: 20'h00040, wdata: 16'h0};
            repeat (6) @(posedge hclk);
            check("sysmem start", {31'h0, sysmem_start}, 32'h1);
            check("no isa strobes", mem_falls - m0 + io_falls - i0, 0);
            if (k == 1) check("rom oe", {31'h0, rom_oe_n}, 32'h0);
            cpu_req.valid <= 1'b0;
            repeat (2) @(posedge hclk);
        end
        // free running modes at each divisor, bus clock on gpio
        ahb(1'b1, `BUS_CTRL_ADDR, 32'h21);
        for (int m = 1; m < 3; m++) begin
            ahb(1'b1, `EXP_BUS_MODE_ADDR, {24'h0, m[1:0], 6'h0});
            ahb(1'b0, `EXP_BUS_MODE_ADDR, 32'h0);
            check("mode readback", rd[7:6], m);
            for (int d = 0; d < 3; d++) begin
                ahb(1'b1, `BCG_MODE_ADDR, {24'h0, 6'h08, d[1:0]});
                clk_count();
                check("sysclk rate", rises - r0, 24 / (4 - d));
                check("gpio sysclk", grises - g0, 24 / (4 - d));
            end
            wide_io <= 1'b1;
            cpu_op(1'b1, 1'b1, 20'h00320);
            check("aligned cycle", cpu_rdata, 32'h8520);
        end
        ahb(1'b1, `BCG_MODE_ADDR, 32'h62);
        @(posedge hclk);
        check("osc divisor 4", {30'h0, osc}, 32'h3);
        end_sim();
    end
endmodule : isa_cycle_control_tb
